/* File: design/scac_pkg.sv */
// Purpose: Shared constants and carrier types for the call/clear decoder.
// Assumes: 14-bit instruction words, 13-bit program counter.
// Notes: Encodings live here only; opcode bits 13:11 and pc bits 12:11 are also written as literals in the modules.
package scac_pkg;

    // ==========================================================
    // Widths and field positions
    localparam int SCAC_IW = 14;
    localparam int SCAC_PCW = 13;
    localparam int SCAC_DW = 8;
    localparam int SCAC_TGT_MSB = 10;
    localparam int SCAC_LATCH_LO = 3;
    localparam int SCAC_LATCH_HI = 4;

    // ==========================================================
    // Encodings
    localparam logic [2:0] SCAC_CALL_OP = 3'h4;
    localparam logic [13:0] SCAC_CLEAR_OP = 14'h0103;
    localparam logic [7:0] SCAC_ACC_RESET = 8'h00;
    localparam logic [7:0] SCAC_ACC_CLEARED = 8'h00;
    localparam logic [12:0] SCAC_PC_RESET = 13'h0000;
    localparam logic [1:0] SCAC_CALL_CYCLES = 2'h2;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [SCAC_IW-1:0] word;
    } scac_instr_t;

    typedef struct packed {
        logic push;
        logic [SCAC_PCW-1:0] addr;
    } scac_push_t;

    typedef enum logic [1:0] {
        SCAC_IDLE,
        SCAC_CALL2
    } scac_state_t;

    typedef struct packed {
        scac_state_t state;
        logic [SCAC_PCW-1:0] pc;
        logic [SCAC_DW-1:0] acc;
        logic zero;
        logic busy;
        logic done;
        scac_push_t push;
    } scac_regs_t;
endpackage

/* File: design/scac_decode.sv */
// Purpose: Classify a 14-bit instruction word.
// Assumes: Word is stable while valid.
// Notes: Pure combinational, no state.
`timescale 1ns/100ps
module scac_decode (
    input wire logic [13:0] word,
    output logic is_call,
    output logic is_clear,
    output logic [10:0] target
);
    import scac_pkg::*;

    assign is_call = (word[13:11] == SCAC_CALL_OP);
    // Clear has no operand field, so the whole word must match
    assign is_clear = (word == SCAC_CLEAR_OP);
    assign target = word[SCAC_TGT_MSB:0];
endmodule

/* File: design/scac_core.sv */
// Purpose: Execute the subroutine call and accumulator_clear instructions.
// Assumes: One instruction offered per cycle via instr, stalled by busy.
// Notes: Other opcodes retire in one cycle; they only advance pc and pulse done here.
// ==========================================================
// Timing overview
// Call, cycle 0: word offered with valid high
// Call, cycle 1: push pulse, new pc, busy high
// Call, cycle 2: done pulse, busy low again
// Call: offer of cycle 1 is dropped silently
// Clear, cycle 0: word offered with valid high
// Clear, cycle 1: acc zero, flag set, pc advanced
// Clear: next word may follow back to back
// Other words: pc advanced, done pulsed, no other effect
//
// ==========================================================
// Hazards and limitations
// Push is a pulse; the stack itself lives outside
// Stack depth and overflow are the stack's own business
// Caller must not offer a word while busy is high
// A word offered during busy is lost, with no sign
// Zero flag after reset is low by choice
// Page latch is sampled only at call acceptance
// Only bits 4:3 of the page latch matter here
// Upper latch bits are ignored on purpose
// Clear needs an exact match: it has no operand field
// Call leaves acc and zero alone in both cycles
//
// ==========================================================
// Width limits
// Program counter width is fixed by the carriers
// Accumulator width is fixed by the carriers
// The elaboration check refuses other values
`timescale 1ns/100ps
module scac_core #(
    parameter int PC_WIDTH = scac_pkg::SCAC_PCW,
    parameter int ACC_WIDTH = scac_pkg::SCAC_DW,
    parameter int WORD_WIDTH = scac_pkg::SCAC_IW
) (
    input wire logic core_clk,
    input wire logic resetn,
    input scac_pkg::scac_instr_t instr,
    input wire logic [7:0] pc_high_latch,
    output logic busy,
    output logic done,
    output scac_pkg::scac_push_t stack_push,
    output logic [12:0] pc,
    output logic [7:0] acc,
    output logic zero_flag
);
    import scac_pkg::*;

    // ==========================================================
    // Elaboration check
    // Carrier structs and ports are sized by the package, so the
    // logic can serve no other widths than these
    if (PC_WIDTH != SCAC_PCW) begin : g_bad_pc
        $error("scac_core: PC_WIDTH must equal the package width");
    end
    if (ACC_WIDTH != SCAC_DW) begin : g_bad_acc
        $error("scac_core: ACC_WIDTH must equal the package width");
    end
    if (WORD_WIDTH != SCAC_IW) begin : g_bad_word
        $error("scac_core: WORD_WIDTH must equal the package width");
    end

    // ==========================================================
    // State and decode results
    // All state sits in one struct; r_next is its next value
    scac_regs_t r_reg;
    scac_regs_t r_next;
    logic is_call;
    logic is_clear;
    logic [10:0] target;

    // ==========================================================
    // Decoder
    scac_decode u_dec (
        .word(instr.word),
        .is_call(is_call),
        .is_clear(is_clear),
        .target(target)
    );

    // ==========================================================
    // Next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.push = '0;
        case (r_reg.state)
            SCAC_IDLE: begin
                if (instr.valid && is_call) begin
                    r_next.push.push = 1'b1;
                    r_next.push.addr = r_reg.pc + 13'h0001;
                    r_next.pc[SCAC_TGT_MSB:0] = target;
                    r_next.pc[12:11] =
                        pc_high_latch[SCAC_LATCH_HI:SCAC_LATCH_LO];
                    r_next.state = SCAC_CALL2;
                    r_next.busy = 1'b1;
                end else if (instr.valid && is_clear) begin
                    r_next.acc = SCAC_ACC_CLEARED;
                    r_next.zero = 1'b1;
                    r_next.pc = r_reg.pc + 13'h0001;
                    r_next.done = 1'b1;
                end else if (instr.valid) begin
                    // Foreign opcode just advances the counter and pulses done
                    r_next.pc = r_reg.pc + 13'h0001;
                    r_next.done = 1'b1;
                end
            end
            SCAC_CALL2: begin
                r_next.state = SCAC_IDLE;
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end
            default: begin
                r_next.state = SCAC_IDLE;
                r_next.busy = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r_reg.state <= SCAC_IDLE;
            r_reg.pc <= SCAC_PC_RESET;
            r_reg.acc <= SCAC_ACC_RESET;
            r_reg.zero <= 1'b0;
            r_reg.busy <= 1'b0;
            r_reg.done <= 1'b0;
            r_reg.push <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from flops
    assign busy = r_reg.busy;
    assign done = r_reg.done;
    assign stack_push = r_reg.push;
    assign pc = r_reg.pc;
    assign acc = r_reg.acc;
    assign zero_flag = r_reg.zero;
endmodule

/* File: test/scac_properties.sv */
// Purpose: Port checks for scac_core.
// Assumes: An instruction is taken when valid and not busy.
// Notes: Bound to every scac_core.
`timescale 1ns/100ps
module scac_properties (
    input wire logic core_clk,
    input wire logic resetn,
    input scac_pkg::scac_instr_t instr,
    input wire logic [7:0] pc_high_latch,
    input wire logic busy,
    input wire logic done,
    input scac_pkg::scac_push_t stack_push,
    input wire logic [12:0] pc,
    input wire logic [7:0] acc,
    input wire logic zero_flag
);
    import scac_pkg::*;
    logic take;
    logic call;
    logic clr;
    // ========
    // Acceptance; an offer during busy is dropped, so it must not count
    assign take = instr.valid && !busy;
    assign call = take && instr.word[13:11] == SCAC_CALL_OP;
    assign clr = take && instr.word == SCAC_CLEAR_OP;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_call_push_ret: assert property (
        call |=> stack_push.push && stack_push.addr == $past(pc) + 13'h0001)
        else $error("Return address push wrong");
    a_call_low_pc: assert property (
        call |=> pc[10:0] == $past(instr.word[10:0]))
        else $error("Call target low bits wrong");
    a_call_page_bits: assert property (
        call |=> pc[12:11] == $past(pc_high_latch[4:3]))
        else $error("Call page bits wrong");
    a_call_two_cycles: assert property (
        call |=> busy && !done ##1 done && !busy)
        else $error("Call length wrong");
    a_other_no_push: assert property (
        take && instr.word[13:11] != SCAC_CALL_OP |=> !stack_push.push)
        else $error("Push on a non-call word");
    a_call_keeps_flag: assert property (
        call |=> $stable(zero_flag) && $stable(acc) ##1 $stable(zero_flag))
        else $error("Call changed zero flag");
    a_clear_sets_zero: assert property (
        clr |=> acc == 8'h00 && zero_flag)
        else $error("Clear result wrong");
    a_clear_one_cycle: assert property (
        clr |=> done && !busy && pc == $past(pc) + 13'h0001)
        else $error("Clear not single cycle");
endmodule
bind scac_core scac_properties u_props (.core_clk(core_clk),
    .resetn(resetn), .instr(instr), .pc_high_latch(pc_high_latch),
    .busy(busy), .done(done), .stack_push(stack_push), .pc(pc),
    .acc(acc), .zero_flag(zero_flag));

/* File: test/tb_subroutine_call_and_acc_clear.sv */
// Purpose: Self-checking bench for scac_core.
// Assumes: Inputs change on the falling edge.
// Notes: Covers call, clear, other words and a refused offer.
`timescale 1ns/100ps
module tb_subroutine_call_and_acc_clear;
    import scac_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    scac_instr_t instr = '0;
    logic [7:0] pc_high_latch = 8'h00;
    logic busy, done, zero_flag;
    scac_push_t stack_push;
    logic [12:0] pc;
    logic [7:0] acc;
    int bad_count = 0;
    int cmp_count = 0;
    // ========
    // Clock and device
    always #2 core_clk = ~core_clk;
    scac_core u_dut (.core_clk(core_clk), .resetn(resetn), .instr(instr),
        .pc_high_latch(pc_high_latch), .busy(busy), .done(done),
        .stack_push(stack_push), .pc(pc), .acc(acc), .zero_flag(zero_flag));
    task automatic chk(logic [12:0] got, logic [12:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("Counts: %0d bad of %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One-cycle word: clear or any other non-call opcode
    task automatic test_plain(logic [13:0] w);
        logic [12:0] p;
        @(negedge core_clk);
        p = pc;
        instr = '{1'b1, w};
        @(negedge core_clk);
        instr.valid = 1'b0;
        chk(stack_push.push, 13'h0000);
        chk(done, 13'h0001);
        chk(pc, p + 13'h0001);
        if (w == SCAC_CLEAR_OP) begin
            chk(acc, 13'h0000);
            chk(zero_flag, 13'h0001);
        end
        $display("Plain word %h finished", w);
    endtask
    // Call, with a clear offered while busy that must be dropped
    task automatic test_call(logic [10:0] k, logic [7:0] lat);
        logic [12:0] p;
        logic z;
        logic [7:0] a;
        @(negedge core_clk);
        p = pc;
        z = zero_flag;
        a = acc;
        pc_high_latch = lat;
        instr = '{1'b1, {SCAC_CALL_OP, k}};
        @(negedge core_clk);
        instr.word = SCAC_CLEAR_OP;
        chk(stack_push.push, 13'h0001);
        chk(stack_push.addr, p + 13'h0001);
        chk(pc, {lat[4:3], k});
        chk(busy, 13'h0001);
        @(negedge core_clk);
        instr.valid = 1'b0;
        chk(done, 13'h0001);
        chk(pc, {lat[4:3], k});
        chk(zero_flag, z);
        chk(acc, a);
        chk(stack_push.push, 13'h0000);
        $display("Call to %h finished", k);
    endtask
    // Mid-run reset: everything back to its reset value
    task automatic test_reset;
        @(negedge core_clk);
        resetn = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(pc, SCAC_PC_RESET);
        chk(acc, 13'h0000);
        chk(zero_flag, 13'h0000);
        chk(busy, 13'h0000);
        chk(done, 13'h0000);
        chk(stack_push.push, 13'h0000);
        resetn = 1'b1;
        $display("Reset finished");
    endtask
    initial begin
        repeat (20) @(negedge core_clk);
        resetn = 1'b1;
        test_plain(14'h2800);
        test_call(11'h123, 8'h10);
        test_plain(SCAC_CLEAR_OP);
        test_plain(SCAC_CLEAR_OP);
        test_call(11'h7FF, 8'h18);
        test_call(11'h000, 8'hE7);
        test_call(11'h555, 8'h08);
        test_reset();
        test_call(11'h2AA, 8'h10);
        tally_and_finish();
    end
endmodule
